// >>> shared/ebram_defines.svh
// Sizing constants for the embedded block RAM.
// Assumes inclusion by bare name from the package and the core.
`ifndef EBRAM_DEFINES_SVH
`define EBRAM_DEFINES_SVH
`define EBRAM_MEM_BITS 9216
`define EBRAM_DATA_W 36
`define EBRAM_ADDR_W 13
`define EBRAM_PTR_W 14
`define EBRAM_BITS_W 6
`define EBRAM_BITS_X1 6'h01
`define EBRAM_BITS_X2 6'h02
`define EBRAM_BITS_X4 6'h04
`define EBRAM_BITS_X9 6'h09
`define EBRAM_BITS_X18 6'h12
`define EBRAM_BITS_X36 6'h24
`define EBRAM_DEPTH_X1 14'h2000
`define EBRAM_DEPTH_X2 14'h1000
`define EBRAM_DEPTH_X4 14'h0800
`define EBRAM_DEPTH_X9 14'h0400
`define EBRAM_DEPTH_X18 14'h0200
`define EBRAM_DEPTH_X36 14'h0100
`define EBRAM_TDP_MAX_BITS 6'h12
`define EBRAM_PTR_ONE 14'h0001
`endif

// >>> shared/ebram_pkg.sv
// Types and width decoding shared by the block RAM core.
// Assumes ebram_defines.svh is on the include path.
`include "ebram_defines.svh"
package ebram_pkg;
    typedef enum logic [1:0] {
        EBRAM_SINGLE = 2'h0,
        EBRAM_TRUE_DUAL = 2'h1,
        EBRAM_PSEUDO_DUAL = 2'h2,
        EBRAM_FIFO = 2'h3
    } ebram_mode_type;

    typedef enum logic [2:0] {
        EBRAM_X1 = 3'h0,
        EBRAM_X2 = 3'h1,
        EBRAM_X4 = 3'h2,
        EBRAM_X9 = 3'h3,
        EBRAM_X18 = 3'h4,
        EBRAM_X36 = 3'h5
    } ebram_width_type;

    typedef enum logic [1:0] {
        EBRAM_WR_NORMAL = 2'h0,
        EBRAM_WR_THROUGH = 2'h1,
        EBRAM_WR_READ_FIRST = 2'h2
    } ebram_wr_mode_type;

    // Data bits per word for a width code
    function automatic logic [`EBRAM_BITS_W-1:0] ebram_bits(
        input ebram_width_type w);
        case (w)
            EBRAM_X1: return `EBRAM_BITS_X1;
            EBRAM_X2: return `EBRAM_BITS_X2;
            EBRAM_X4: return `EBRAM_BITS_X4;
            EBRAM_X9: return `EBRAM_BITS_X9;
            EBRAM_X18: return `EBRAM_BITS_X18;
            default: return `EBRAM_BITS_X36;
        endcase
    endfunction : ebram_bits

    // Words per block for a width code
    function automatic logic [`EBRAM_PTR_W-1:0] ebram_depth(
        input ebram_width_type w);
        case (w)
            EBRAM_X1: return `EBRAM_DEPTH_X1;
            EBRAM_X2: return `EBRAM_DEPTH_X2;
            EBRAM_X4: return `EBRAM_DEPTH_X4;
            EBRAM_X9: return `EBRAM_DEPTH_X9;
            EBRAM_X18: return `EBRAM_DEPTH_X18;
            default: return `EBRAM_DEPTH_X36;
        endcase
    endfunction : ebram_depth
endpackage : ebram_pkg

// >>> src/ebram_core.sv
// Embedded block RAM: two ports, four arrangements, FIFO flag logic.
// Assumes both ports are driven by fabric logic on core_clk and that the
// arrangement and width inputs are held steady during traffic.
`timescale 1ns/10ps
`include "ebram_defines.svh"
module ebram_core #(
    parameter logic [`EBRAM_MEM_BITS-1:0] INIT_IMAGE = '0 // Preload image
) (
    input wire logic core_clk, // 125 MHz clock for both ports
    input wire logic rst, // Synchronous reset, loads the image
    input wire ebram_pkg::ebram_mode_type mode, // Memory arrangement
    input wire ebram_pkg::ebram_width_type width_a, // Port A width
    input wire ebram_pkg::ebram_width_type width_b, // Port B width
    input wire ebram_pkg::ebram_wr_mode_type wr_mode_a, // Port A write mode
    input wire ebram_pkg::ebram_wr_mode_type wr_mode_b, // Port B write mode
    input wire logic out_reg_a, // Port A output register on
    input wire logic out_reg_b, // Port B output register on
    input wire logic ce_a, // Port A enable (FIFO: push qualifier)
    input wire logic we_a, // Port A write
    input wire logic [`EBRAM_ADDR_W-1:0] addr_a, // Port A word address
    input wire logic [`EBRAM_DATA_W-1:0] din_a, // Port A write data
    output logic [`EBRAM_DATA_W-1:0] dout_a, // Port A read data
    input wire logic ce_b, // Port B enable (FIFO: pop)
    input wire logic we_b, // Port B write
    input wire logic [`EBRAM_ADDR_W-1:0] addr_b, // Port B word address
    input wire logic [`EBRAM_DATA_W-1:0] din_b, // Port B write data
    output logic [`EBRAM_DATA_W-1:0] dout_b, // Port B read data
    input wire logic [`EBRAM_PTR_W-1:0] full_level, // FIFO full level
    input wire logic [`EBRAM_PTR_W-1:0] almost_full_level, // Almost full
    input wire logic [`EBRAM_PTR_W-1:0] almost_empty_level, // Almost empty
    output logic full_flag, // FIFO full
    output logic almost_full_flag, // FIFO almost full
    output logic empty_flag, // FIFO empty
    output logic almost_empty_flag, // FIFO almost empty
    output logic config_ok // Arrangement and widths are legal
);
    import ebram_pkg::*;

    logic mem [0:`EBRAM_MEM_BITS-1];
    logic ce_a_q, we_a_q, ce_b_q, we_b_q;
    logic [`EBRAM_ADDR_W-1:0] addr_a_q, addr_b_q;
    logic [`EBRAM_DATA_W-1:0] din_a_q, din_b_q;
    logic [`EBRAM_DATA_W-1:0] latch_a, latch_b, oreg_a, oreg_b;
    logic [`EBRAM_DATA_W-1:0] rd_data_a, rd_data_b;
    logic [`EBRAM_BITS_W-1:0] bits_a, bits_b;
    logic [`EBRAM_ADDR_W-1:0] wr_ptr, rd_ptr, word_a, word_b;
    logic [`EBRAM_PTR_W-1:0] count, next_count, depth;
    logic cfg_good, is_fifo, wr_a, wr_b, rd_a, rd_b, push, pop;
    int base_a, base_b;

    // Read one word of a port's width from its contiguous bit span
    function automatic logic [`EBRAM_DATA_W-1:0] ebram_read(
        input int base, input logic [`EBRAM_BITS_W-1:0] bits);
        logic [`EBRAM_DATA_W-1:0] v;
        v = '0;
        for (int i = 0; i < `EBRAM_DATA_W; i++) begin
            if (i < int'(bits) && base + i < `EBRAM_MEM_BITS) begin
                v[i] = mem[base + i];
            end
        end
        return v;
    endfunction : ebram_read

    // Next output latch value for one port, by its write behaviour
    function automatic logic [`EBRAM_DATA_W-1:0] ebram_next_out(
        input logic [`EBRAM_DATA_W-1:0] cur,
        input logic wr, input logic rd, input ebram_wr_mode_type wm,
        input ebram_width_type w, input logic [`EBRAM_DATA_W-1:0] din,
        input logic [`EBRAM_DATA_W-1:0] old);
        logic [`EBRAM_DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < `EBRAM_DATA_W; i++) begin
            m[i] = (i < int'(ebram_bits(w)));
        end
        if (wr) begin
            unique case (wm)
                EBRAM_WR_THROUGH: return din & m;
                // Old contents only exist as whole bytes-plus-parity words
                EBRAM_WR_READ_FIRST: return (w == EBRAM_X9 ||
                    w == EBRAM_X18 || w == EBRAM_X36) ? old : cur;
                default: return cur;
            endcase
        end
        return rd ? old : cur;
    endfunction : ebram_next_out

    // Legal setups; true dual port stops at x18, FIFO needs equal widths
    assign bits_a = ebram_bits(width_a);
    assign bits_b = ebram_bits(width_b);
    assign cfg_good = !(mode == EBRAM_TRUE_DUAL &&
        (bits_a > `EBRAM_TDP_MAX_BITS || bits_b > `EBRAM_TDP_MAX_BITS)) &&
        !(mode == EBRAM_FIFO && width_a != width_b);
    assign is_fifo = (mode == EBRAM_FIFO);

    // Input registers on every port, ahead of the array
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ce_a_q <= '0;
            we_a_q <= '0;
            ce_b_q <= '0;
            we_b_q <= '0;
            addr_a_q <= '0;
            addr_b_q <= '0;
            din_a_q <= '0;
            din_b_q <= '0;
        end else begin
            ce_a_q <= ce_a;
            we_a_q <= we_a;
            ce_b_q <= ce_b;
            we_b_q <= we_b;
            addr_a_q <= addr_a;
            addr_b_q <= addr_b;
            din_a_q <= din_a;
            din_b_q <= din_b;
        end
    end

    // Port roles per arrangement; an illegal setup freezes the array
    always_comb begin
        wr_a = '0;
        wr_b = '0;
        rd_a = '0;
        rd_b = '0;
        if (cfg_good) begin
            unique case (mode)
                EBRAM_SINGLE: begin
                    wr_a = ce_a_q & we_a_q;
                    rd_a = ce_a_q & ~we_a_q;
                end
                EBRAM_TRUE_DUAL: begin
                    wr_a = ce_a_q & we_a_q;
                    rd_a = ce_a_q & ~we_a_q;
                    wr_b = ce_b_q & we_b_q;
                    rd_b = ce_b_q & ~we_b_q;
                end
                EBRAM_PSEUDO_DUAL: begin
                    wr_a = ce_a_q & we_a_q;
                    rd_b = ce_b_q;
                end
                EBRAM_FIFO: begin
                    wr_a = ce_a_q & we_a_q & ~full_flag;
                    rd_b = ce_b_q & ~empty_flag;
                end
            endcase
        end
    end

    assign push = is_fifo & wr_a;
    assign pop = is_fifo & rd_b;
    assign word_a = is_fifo ? wr_ptr : addr_a_q;
    assign word_b = is_fifo ? rd_ptr : addr_b_q;
    assign base_a = int'(word_a) * int'(bits_a);
    assign base_b = int'(word_b) * int'(bits_b);
    // Processes, not assigns: a write to the array must refresh the word
    always_comb rd_data_a = ebram_read(base_a, bits_a);
    always_comb rd_data_b = ebram_read(base_b, bits_b);

    // Array writes; port B lands last, so a same-address clash keeps B
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < `EBRAM_MEM_BITS; i++) begin
                mem[i] <= INIT_IMAGE[i];
            end
        end else begin
            for (int i = 0; i < `EBRAM_DATA_W; i++) begin
                if (wr_a && i < int'(bits_a) &&
                    base_a + i < `EBRAM_MEM_BITS) begin
                    mem[base_a + i] <= din_a_q[i];
                end
                if (wr_b && i < int'(bits_b) &&
                    base_b + i < `EBRAM_MEM_BITS) begin
                    mem[base_b + i] <= din_b_q[i];
                end
            end
        end
    end

    // Output latches and optional output registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            latch_a <= '0;
            latch_b <= '0;
            oreg_a <= '0;
            oreg_b <= '0;
        end else begin
            latch_a <= ebram_next_out(latch_a, wr_a, rd_a, wr_mode_a,
                width_a, din_a_q, rd_data_a);
            latch_b <= ebram_next_out(latch_b, wr_b, rd_b, wr_mode_b,
                width_b, din_b_q, rd_data_b);
            oreg_a <= latch_a;
            oreg_b <= latch_b;
        end
    end
    assign dout_a = out_reg_a ? oreg_a : latch_a;
    assign dout_b = out_reg_b ? oreg_b : latch_b;

    // FIFO pointers wrap at the depth of the chosen width
    assign depth = ebram_depth(width_a);
    assign next_count = count + `EBRAM_PTR_W'(push) - `EBRAM_PTR_W'(pop);
    always_ff @(posedge core_clk) begin
        if (rst || !is_fifo) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            count <= next_count;
            if (push) begin
                wr_ptr <= ({1'b0, wr_ptr} == depth - `EBRAM_PTR_ONE) ?
                    '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= ({1'b0, rd_ptr} == depth - `EBRAM_PTR_ONE) ?
                    '0 : rd_ptr + 1'b1;
            end
        end
    end

    // Flags registered from the next fill; full also caps at the depth
    always_ff @(posedge core_clk) begin
        if (rst) begin
            full_flag <= '0;
            almost_full_flag <= '0;
            empty_flag <= '1;
            almost_empty_flag <= '1;
            config_ok <= '0;
        end else begin
            full_flag <= is_fifo &&
                (next_count >= full_level || next_count == depth);
            almost_full_flag <= is_fifo &&
                next_count >= almost_full_level;
            empty_flag <= !is_fifo || next_count == '0;
            almost_empty_flag <= !is_fifo ||
                next_count <= almost_empty_level;
            config_ok <= cfg_good;
        end
    end

    // Checks on the port A data path, the true dual port width limit and the FIFO flags
    default clocking ebram_cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_bypass_latency: assert property (rd_a && !out_reg_a
        ##1 !out_reg_a |-> dout_a == $past(rd_data_a))
        else $error("bypass read late");
    a_oreg_latency: assert property (rd_a && out_reg_a ##1 out_reg_a
        ##1 out_reg_a |-> dout_a == $past(rd_data_a, 2))
        else $error("registered read late");
    a_through_data: assert property (wr_a && width_a == EBRAM_X36 &&
        wr_mode_a == EBRAM_WR_THROUGH |=> latch_a == $past(din_a_q))
        else $error("write-through data wrong");
    a_normal_hold: assert property (wr_a &&
        wr_mode_a == EBRAM_WR_NORMAL |=> $stable(latch_a))
        else $error("normal write moved out");
    a_read_first_old: assert property (wr_a &&
        width_a == EBRAM_X36 && wr_mode_a == EBRAM_WR_READ_FIRST |=>
        latch_a == $past(rd_data_a))
        else $error("read-before-write lost old");
    a_write_stored: assert property (wr_a && !wr_b &&
        base_a < `EBRAM_MEM_BITS |=> mem[$past(base_a)] == $past(din_a_q[0]))
        else $error("write not stored");
    a_input_capture: assert property (ce_a ##1 ce_a_q ##1 1 |->
        $past(addr_a, 2) == $past(addr_a_q)) else $error("no capture");
    a_tdp_limit: assert property (mode == EBRAM_TRUE_DUAL &&
        (width_a == EBRAM_X36 || width_b == EBRAM_X36) |=> !config_ok)
        else $error("true dual port accepted x36");
    a_full_no_push: assert property (is_fifo && full_flag && !pop |=>
        count == $past(count)) else $error("push past full");
    a_empty_tracks: assert property (is_fifo |->
        empty_flag == (count == '0)) else $error("empty flag off");

    c_fifo_full: cover property (is_fifo && full_flag);
    c_fifo_drain: cover property (pop ##1 empty_flag);
    c_read_first_a: cover property (wr_a && wr_mode_a == EBRAM_WR_READ_FIRST);
    c_dual_write: cover property (wr_a && wr_b);
endmodule : ebram_core

// >>> tb/ebram_user_model.sv
// Fabric user logic model: drives every input of the block RAM except core_clk and rst.
// Assumes the bench sequences it through its tasks on core_clk.
`timescale 1ns/10ps
module ebram_user_model (
    input wire logic core_clk, // Shared clock
    output ebram_pkg::ebram_mode_type mode, // Arrangement
    output ebram_pkg::ebram_width_type width_a, // A width
    output ebram_pkg::ebram_width_type width_b, // B width
    output ebram_pkg::ebram_wr_mode_type wr_mode_a, // A write mode
    output ebram_pkg::ebram_wr_mode_type wr_mode_b, // B write mode
    output logic out_reg_a, // A output register
    output logic out_reg_b, // B output register
    output logic ce_a, // A enable
    output logic we_a, // A write
    output logic [12:0] addr_a, // A address
    output logic [35:0] din_a, // A data
    output logic ce_b, // B enable
    output logic we_b, // B write
    output logic [12:0] addr_b, // B address
    output logic [35:0] din_b, // B data
    output logic [13:0] full_level, // Full level
    output logic [13:0] almost_full_level, // Almost full level
    output logic [13:0] almost_empty_level // Almost empty level
);
    import ebram_pkg::*;
    // Quiet start; enums are set one by one, never through a concatenation
    initial begin
        mode = EBRAM_SINGLE;
        width_a = EBRAM_X36;
        width_b = EBRAM_X36;
        wr_mode_a = EBRAM_WR_NORMAL;
        wr_mode_b = EBRAM_WR_NORMAL;
        {out_reg_a, out_reg_b, ce_a, we_a, ce_b, we_b} = 6'h00;
        {addr_a, addr_b, din_a, din_b} = '0;
        full_level = 14'h0004;
        almost_full_level = 14'h0003;
        almost_empty_level = 14'h0001;
    end
    task automatic tk();
        @(posedge core_clk);
    endtask : tk
    // One access on a port, held until the next call
    task automatic pa(input logic w, input logic [12:0] a,
        input logic [35:0] d);
        {ce_a, we_a, addr_a, din_a} <= {1'h1, w, a, d};
    endtask : pa
    task automatic pb(input logic w, input logic [12:0] a,
        input logic [35:0] d);
        {ce_b, we_b, addr_b, din_b} <= {1'h1, w, a, d};
    endtask : pb
    // Release: released lines flip so a stale value never matches
    task automatic rs();
        {ce_a, we_a, ce_b, we_b} <= 4'h0;
        {addr_a, din_a} <= ~{addr_a, din_a};
        {addr_b, din_b} <= ~{addr_b, din_b};
    endtask : rs
    // New arrangement with ports idle; config_ok follows one edge later
    task automatic cfg(input ebram_mode_type m, input ebram_width_type a,
        input ebram_width_type b, input ebram_wr_mode_type w,
        input logic r);
        tk();
        rs();
        mode <= m;
        width_a <= a;
        width_b <= b;
        wr_mode_a <= w;
        wr_mode_b <= w;
        out_reg_a <= r;
        out_reg_b <= r;
        repeat (2) tk();
    endtask : cfg
endmodule : ebram_user_model

// >>> tb/embedded_block_ram_tb.sv
// Self-checking bench for the embedded block RAM core.
// Assumes the user model drives every core input other than core_clk and rst on core_clk.
`timescale 1ns/10ps
module embedded_block_ram_tb;
    import ebram_pkg::*;
    localparam logic [35:0] IMG = 36'h9_a5c3_1e7f;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    ebram_mode_type mode;
    ebram_width_type width_a, width_b;
    ebram_wr_mode_type wr_mode_a, wr_mode_b;
    logic out_reg_a, out_reg_b, ce_a, we_a, ce_b, we_b, config_ok;
    logic [12:0] addr_a, addr_b;
    logic [35:0] din_a, din_b, dout_a, dout_b, d;
    logic [13:0] full_level, almost_full_level, almost_empty_level;
    logic full_flag, almost_full_flag, empty_flag, almost_empty_flag;

    // 125 MHz
    always #4 core_clk = ~core_clk;

    ebram_core #(.INIT_IMAGE({256{IMG}})) u_ebram_core (.core_clk, .rst,
        .mode, .width_a, .width_b, .wr_mode_a, .wr_mode_b, .out_reg_a,
        .out_reg_b, .ce_a, .we_a, .addr_a, .din_a, .dout_a, .ce_b, .we_b,
        .addr_b, .din_b, .dout_b, .full_level, .almost_full_level,
        .almost_empty_level, .full_flag, .almost_full_flag, .empty_flag,
        .almost_empty_flag, .config_ok);
    ebram_user_model u_ebram_user_model (.core_clk, .mode, .width_a,
        .width_b, .wr_mode_a, .wr_mode_b, .out_reg_a, .out_reg_b, .ce_a,
        .we_a, .addr_a, .din_a, .ce_b, .we_b, .addr_b, .din_b, .full_level,
        .almost_full_level, .almost_empty_level);

    task automatic report_and_stop();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string s, input logic [35:0] e,
        input logic [35:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic chkb(input string s, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", s, e, g);
        end
    endtask : chkb
    // Read on one port, sampled lat edges after capture
    task automatic rd(input logic sb, input logic [12:0] a,
        input logic [35:0] e, input int lat);
        u_ebram_user_model.tk();
        if (sb) u_ebram_user_model.pb(1'h0, a, '0);
        else u_ebram_user_model.pa(1'h0, a, '0);
        u_ebram_user_model.tk();
        u_ebram_user_model.rs();
        repeat (lat) u_ebram_user_model.tk();
        #1;
        chk(sb ? "dout_b" : "dout_a", e, sb ? dout_b : dout_a);
    endtask : rd
    // Write on port A, returns once the write has executed
    task automatic wr(input logic [12:0] a, input logic [35:0] v);
        u_ebram_user_model.tk();
        u_ebram_user_model.pa(1'h1, a, v);
        u_ebram_user_model.tk();
        u_ebram_user_model.rs();
        u_ebram_user_model.tk();
        #1;
    endtask : wr
    task automatic cf(input ebram_mode_type m, input ebram_width_type a,
        input ebram_width_type b, input int w, input logic r);
        u_ebram_user_model.cfg(m, a, b, ebram_wr_mode_type'(w), r);
        #1;
    endtask : cf

    // Hang guard: the sequence needs about 150 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        #1;
        chkb("empty_flag", 1'h1, empty_flag);
        chkb("almost_empty_flag", 1'h1, almost_empty_flag);
        chkb("full_flag", 1'h0, full_flag);
        chk("dout_a", '0, dout_a);
        cf(EBRAM_SINGLE, EBRAM_X36, EBRAM_X36, 0, 1'h0);
        chkb("config_ok", 1'h1, config_ok);
        rd(1'h0, 13'h00c8, IMG, 1);
        wr(13'h0014, '0);
        // Each write behaviour, starting from an output that read zero
        for (int m = 0; m < 3; m++) begin
            d = 36'h5_0f0f_0000 + 36'(m);
            cf(EBRAM_SINGLE, EBRAM_X36, EBRAM_X36, m, 1'h0);
            rd(1'h0, 13'h0014, '0, 1);
            wr(13'h0001 + 13'(m), d);
            chk("dout_a", m == 0 ? '0 : (m == 1 ? d : IMG), dout_a);
            rd(1'h0, 13'h0001 + 13'(m), d, 1);
        end
        // Registered output: back-to-back reads arrive one edge later
        cf(EBRAM_SINGLE, EBRAM_X36, EBRAM_X36, 0, 1'h1);
        u_ebram_user_model.tk();
        u_ebram_user_model.pa(1'h0, 13'h0001, '0);
        u_ebram_user_model.tk();
        u_ebram_user_model.pa(1'h0, 13'h0002, '0);
        u_ebram_user_model.tk();
        u_ebram_user_model.rs();
        u_ebram_user_model.tk();
        #1;
        chk("dout_a", 36'h5_0f0f_0000, dout_a);
        u_ebram_user_model.tk();
        #1;
        chk("dout_a", 36'h5_0f0f_0001, dout_a);
        // Read-before-write is not offered at x4: output holds
        cf(EBRAM_SINGLE, EBRAM_X4, EBRAM_X4, 2, 1'h0);
        rd(1'h0, 13'h00b4, '0, 1);
        wr(13'h00c8, 36'h0_0000_0005);
        chk("dout_a", '0, dout_a);
        rd(1'h0, 13'h00c8, 36'h0_0000_0005, 1);
        // Wide writes seen through narrow ports
        d = 36'h8_7654_3210;
        cf(EBRAM_PSEUDO_DUAL, EBRAM_X36, EBRAM_X9, 0, 1'h0);
        wr(13'h001e, d);
        for (int k = 0; k < 4; k++) begin
            rd(1'h1, 13'h0078 + 13'(k), {27'h0, d[9*k +: 9]}, 1);
        end
        cf(EBRAM_PSEUDO_DUAL, EBRAM_X36, EBRAM_X1, 0, 1'h0);
        rd(1'h1, 13'h043c, 36'h0_0000_0001, 1);
        cf(EBRAM_TRUE_DUAL, EBRAM_X36, EBRAM_X18, 0, 1'h0);
        chkb("config_ok", 1'h0, config_ok);
        cf(EBRAM_FIFO, EBRAM_X9, EBRAM_X18, 0, 1'h0);
        chkb("config_ok", 1'h0, config_ok);
        cf(EBRAM_TRUE_DUAL, EBRAM_X18, EBRAM_X9, 0, 1'h0);
        chkb("config_ok", 1'h1, config_ok);
        // Both ports write in one cycle, distinct addresses
        cf(EBRAM_TRUE_DUAL, EBRAM_X18, EBRAM_X18, 0, 1'h0);
        u_ebram_user_model.tk();
        u_ebram_user_model.pa(1'h1, 13'h0032, 36'h0_0001_2345);
        u_ebram_user_model.pb(1'h1, 13'h0033, 36'h0_0002_abcd);
        u_ebram_user_model.tk();
        u_ebram_user_model.rs();
        rd(1'h1, 13'h0032, 36'h0_0001_2345, 1);
        rd(1'h0, 13'h0033, 36'h0_0002_abcd, 1);
        // FIFO: five pushes against a level of four, then drain
        cf(EBRAM_FIFO, EBRAM_X9, EBRAM_X9, 0, 1'h0);
        for (int k = 0; k < 5; k++) begin
            u_ebram_user_model.tk();
            u_ebram_user_model.pa(1'h1, '0, 36'h0_0000_00a0 + 36'(k));
        end
        u_ebram_user_model.tk();
        u_ebram_user_model.rs();
        u_ebram_user_model.tk();
        #1;
        chkb("full_flag", 1'h1, full_flag);
        chkb("empty_flag", 1'h0, empty_flag);
        chkb("almost_full_flag", 1'h1, almost_full_flag);
        chkb("almost_empty_flag", 1'h0, almost_empty_flag);
        for (int k = 0; k < 4; k++) begin
            rd(1'h1, '0, 36'h0_0000_00a0 + 36'(k), 1);
        end
        chkb("empty_flag", 1'h1, empty_flag);
        chkb("full_flag", 1'h0, full_flag);
        chkb("almost_full_flag", 1'h0, almost_full_flag);
        chkb("almost_empty_flag", 1'h1, almost_empty_flag);
        report_and_stop();
    end
endmodule : embedded_block_ram_tb
